// *** abt_bridge.sv ***
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module abt_bridge #(
  parameter bit                                  INCLUDE_FIFO                   = 1'b1,
  parameter bit                                  runtime_offset_register_select = 1'b0,
  parameter int                                  local_window_count             = 6,
  parameter logic [abt_pkg::WIN_L-1:0][31:0]     local_window_base   = abt_pkg::L_BASE_DEF,
  parameter logic [abt_pkg::WIN_L-1:0][31:0]     local_window_high   = abt_pkg::L_HIGH_DEF,
  parameter logic [abt_pkg::WIN_L-1:0][31:0]     local_to_remote_high_bits = abt_pkg::L_XLATE_DEF,
  parameter logic [abt_pkg::WIN_L-1:0]           local_window_byte_order_select = abt_pkg::L_BO_DEF,
  parameter logic [abt_pkg::WIN_L-1:0]           local_window_prefetchable = abt_pkg::L_PF_DEF,
  parameter logic [abt_pkg::WIN_L-1:0]           local_window_space_type = abt_pkg::L_MEM_DEF,
  parameter logic [abt_pkg::WIN_R-1:0][4:0]      remote_window_size_log2 = abt_pkg::R_LOG2_DEF,
  parameter logic [abt_pkg::WIN_R-1:0][31:0]     remote_to_local_high_bits = abt_pkg::R_XLATE_DEF,
  parameter logic [abt_pkg::WIN_R-1:0]           remote_window_byte_order_select = abt_pkg::R_BO_DEF,
  parameter logic [abt_pkg::WIN_R-1:0]           remote_window_prefetchable = abt_pkg::R_PF_DEF
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [31:0]        wb_dat_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic               wb_we_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  input  wire abt_pkg::abt_lreq_s lreq,
  input  wire logic               lreq_valid,
  output logic                    lreq_ready,
  output logic [31:0]             lrsp_data,
  output logic                    lrsp_valid,
  input  wire abt_pkg::abt_treq_s treq,
  input  wire logic               treq_valid,
  output abt_pkg::abt_tfwd_s      tfwd,
  output logic                    tfwd_valid,
  input  wire logic               link_clk,
  input  wire logic               gnt_n,
  input  wire logic               frame_n_i,
  input  wire logic               irdy_n_i,
  input  wire logic               trdy_n,
  input  wire logic [31:0]        ad_i,
  output logic [31:0]             ad_o,
  output logic                    ad_oe,
  output logic [3:0]              cbe_n_o,
  output logic                    frame_n_o,
  output logic                    irdy_n_o,
  output logic                    ctl_oe,
  output logic                    req_n
);
  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_TURN} abt_st_e;

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  logic [31:0]                       ctrl_r;
  logic [7:0]                        lat_r;
  logic [abt_pkg::WIN_L-1:0][31:0]   lofs_r;
  logic [abt_pkg::WIN_R-1:0][31:0]   rbas_r;
  logic                              ack_r;
  logic [31:0]                       rdat_r;
  logic [31:0]                       rdat_nxt;
  logic [31:0]                       wmask;
  logic [31:0]                       rattr;
  logic [31:0]                       stat;
  logic                              wb_req;
  logic                              wb_wr;
  logic                              hit_lofs;
  logic                              hit_rbas;
  logic [2:0]                        idx_lofs;
  logic [1:0]                        idx_rbas;
  abt_st_e                           st_r;

  assign wb_req   = wb_cyc_i && wb_stb_i && !ack_r;
  assign wb_wr    = wb_req && wb_we_i;
  assign hit_lofs = (wb_adr_i >= abt_pkg::REG_LOFS0) && (wb_adr_i < abt_pkg::REG_LOFS0 + 8'h18);
  assign hit_rbas = (wb_adr_i >= abt_pkg::REG_RBAS0) && (wb_adr_i < abt_pkg::REG_RBAS0 + 8'h0C);
  assign idx_lofs = 3'((wb_adr_i - abt_pkg::REG_LOFS0) >> 2);
  assign idx_rbas = 2'((wb_adr_i - abt_pkg::REG_RBAS0) >> 2);
  assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign stat     = {29'h0, st_r};

  // Remote windows always report memory space with their prefetch flag.
  generate
    for (genvar r = 0; r < abt_pkg::WIN_R; r++) begin : g_attr
      assign rattr[r*8 +: 8] = {4'h0, remote_window_prefetchable[r], 3'h0};
    end
  endgenerate
  assign rattr[31:24] = 8'h00;

  always_comb begin
    rdat_nxt = 32'h0000_0000;
    if (wb_adr_i == abt_pkg::REG_CTRL) begin
      rdat_nxt = ctrl_r;
    end else if (wb_adr_i == abt_pkg::REG_LAT) begin
      rdat_nxt = {24'h0, lat_r};
    end else if (wb_adr_i == abt_pkg::REG_STAT) begin
      rdat_nxt = stat;
    end else if (wb_adr_i == abt_pkg::REG_RATTR) begin
      rdat_nxt = rattr;
    end else if (hit_lofs) begin
      rdat_nxt = lofs_r[idx_lofs];
    end else if (hit_rbas) begin
      rdat_nxt = rbas_r[idx_rbas];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h0000_0000;
      ctrl_r <= abt_pkg::CTRL_RST;
      lat_r  <= abt_pkg::LAT_RST;
      lofs_r <= {abt_pkg::WIN_L{abt_pkg::LOFS_RST}};
      rbas_r <= {abt_pkg::WIN_R{abt_pkg::RBAS_RST}};
    end else begin
      ack_r  <= wb_req;
      rdat_r <= rdat_nxt;
      if (wb_wr && wb_adr_i == abt_pkg::REG_CTRL) begin
        ctrl_r <= (ctrl_r & ~wmask) | (wb_dat_i & wmask);
      end
      if (wb_wr && wb_adr_i == abt_pkg::REG_LAT && wb_sel_i[0]) begin
        lat_r <= wb_dat_i[7:0];
      end
      if (wb_wr && hit_lofs) begin
        lofs_r[idx_lofs] <= (lofs_r[idx_lofs] & ~wmask) | (wb_dat_i & wmask);
      end
      if (wb_wr && hit_rbas) begin
        rbas_r[idx_rbas] <= (rbas_r[idx_rbas] & ~wmask) | (wb_dat_i & wmask);
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  //////////////////////////////////////////////////////////////////////////////
  // Local window decode and translation.
  logic [abt_pkg::WIN_L-1:0]         l_hit;
  logic [abt_pkg::WIN_L-1:0][31:0]   l_xa;
  logic                              l_any;
  logic [2:0]                        l_sel;

  generate
    for (genvar i = 0; i < abt_pkg::WIN_L; i++) begin : g_lwin
      abt_win u_win (
        .en    (i < local_window_count),
        .xl    (INCLUDE_FIFO),
        .addr  (lreq.addr),
        .base  (local_window_base[i]),
        .high  (local_window_high[i]),
        .mask  (abt_pkg::common_mask(local_window_base[i], local_window_high[i])),
        .repl  (runtime_offset_register_select ? lofs_r[i] : local_to_remote_high_bits[i]),
        .hit   (l_hit[i]),
        .xaddr (l_xa[i])
      );
    end
  endgenerate

  always_comb begin
    l_sel = 3'h0;
    for (int i = abt_pkg::WIN_L - 1; i >= 0; i--) begin
      if (l_hit[i]) begin
        l_sel = 3'(i);
      end
    end
  end
  assign l_any = |l_hit;

  // Remote windows decode against the base the host wrote into the BAR.
  logic [abt_pkg::WIN_R-1:0]         r_hit;
  logic [abt_pkg::WIN_R-1:0][31:0]   r_xa;
  logic [1:0]                        r_sel;

  generate
    for (genvar j = 0; j < abt_pkg::WIN_R; j++) begin : g_rwin
      abt_win u_win (
        .en    (1'b1),
        .xl    (INCLUDE_FIFO),
        .addr  (treq.addr),
        .base  (rbas_r[j] & abt_pkg::size_mask(remote_window_size_log2[j])),
        .high  ((rbas_r[j] & abt_pkg::size_mask(remote_window_size_log2[j]))
                | ~abt_pkg::size_mask(remote_window_size_log2[j])),
        .mask  (abt_pkg::size_mask(remote_window_size_log2[j])),
        .repl  (remote_to_local_high_bits[j]),
        .hit   (r_hit[j]),
        .xaddr (r_xa[j])
      );
    end
  endgenerate
  assign r_sel = r_hit[0] ? 2'h0 : (r_hit[1] ? 2'h1 : 2'h2);

  // Inbound accesses are memory only; a miss is not forwarded.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tfwd_valid <= 1'b0;
      tfwd       <= '0;
    end else begin
      tfwd_valid <= treq_valid && (|r_hit);
      tfwd.addr  <= r_xa[r_sel];
      tfwd.we    <= treq.we;
      tfwd.win   <= r_sel;
      tfwd.data  <= (INCLUDE_FIFO && remote_window_byte_order_select[r_sel])
                    ? treq.data : abt_pkg::swap32(treq.data);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Link side sampling: every pin passes two flops first.
  logic [2:0]  lclk_s;
  logic [1:0]  gnt_s;
  logic [1:0]  frm_s;
  logic [1:0]  irdy_s;
  logic [1:0]  trdy_s;
  logic [31:0] ad_s1;
  logic [31:0] ad_s2;
  logic        pe;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lclk_s <= 3'h0;
      gnt_s  <= 2'h3;
      frm_s  <= 2'h3;
      irdy_s <= 2'h3;
      trdy_s <= 2'h3;
      ad_s1  <= 32'h0000_0000;
      ad_s2  <= 32'h0000_0000;
    end else begin
      lclk_s <= {lclk_s[1:0], link_clk};
      gnt_s  <= {gnt_s[0], gnt_n};
      frm_s  <= {frm_s[0], frame_n_i};
      irdy_s <= {irdy_s[0], irdy_n_i};
      trdy_s <= {trdy_s[0], trdy_n};
      ad_s1  <= ad_i;
      ad_s2  <= ad_s1;
    end
  end
  assign pe = lclk_s[1] && !lclk_s[2];

  //////////////////////////////////////////////////////////////////////////////
  // Initiator.
  logic [31:0] cur_a_r;
  logic [31:0] cur_d_r;
  logic        cur_we_r;
  logic        cur_last_r;
  logic        cur_io_r;
  logic        cur_bo_r;
  logic [1:0]  gcnt_r;
  logic [7:0]  lcnt_r;
  logic        expired;
  logic        take;
  logic        final_ph;
  logic [31:0] out_d;

  assign expired  = (lcnt_r >= lat_r);
  // Without buffers every access is a single word.
  assign final_ph = cur_last_r || expired || !INCLUDE_FIFO;
  assign take     = lreq_valid && ((st_r == ST_IDLE && ctrl_r[abt_pkg::CTRL_EN_BIT])
                    || (st_r == ST_DATA && pe && !trdy_s[1] && !frame_n_o && cur_we_r));
  assign lreq_ready = take;
  assign out_d    = (INCLUDE_FIFO && cur_bo_r) ? cur_d_r : abt_pkg::swap32(cur_d_r);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r       <= ST_IDLE;
      cur_a_r    <= 32'h0000_0000;
      cur_d_r    <= 32'h0000_0000;
      cur_we_r   <= 1'b0;
      cur_last_r <= 1'b0;
      cur_io_r   <= 1'b0;
      cur_bo_r   <= 1'b0;
      gcnt_r     <= 2'h0;
      lcnt_r     <= 8'h00;
      req_n      <= 1'b1;
      frame_n_o  <= 1'b1;
      irdy_n_o   <= 1'b1;
      ctl_oe     <= 1'b0;
      ad_oe      <= 1'b0;
      ad_o       <= 32'h0000_0000;
      cbe_n_o    <= 4'h0;
      lrsp_valid <= 1'b0;
      lrsp_data  <= 32'h0000_0000;
    end else begin
      lrsp_valid <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (take && l_any) begin
            cur_a_r    <= l_xa[l_sel];
            cur_d_r    <= lreq.data;
            cur_we_r   <= lreq.we;
            cur_last_r <= lreq.last || !lreq.we;
            cur_io_r   <= !local_window_space_type[l_sel];
            cur_bo_r   <= local_window_byte_order_select[l_sel];
            st_r       <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (pe) begin
            req_n  <= 1'b0;
            gcnt_r <= (!req_n && !gnt_s[1]) ? ((gcnt_r < abt_pkg::GNT_HOLD) ? gcnt_r + 2'h1
                      : gcnt_r) : 2'h0;
            if (gcnt_r == abt_pkg::GNT_HOLD - 2'h1 && !gnt_s[1] && frm_s[1] && irdy_s[1]) begin
              st_r      <= ST_ADDR;
              frame_n_o <= 1'b0;
              ctl_oe    <= 1'b1;
              ad_oe     <= 1'b1;
              ad_o      <= cur_a_r;
              cbe_n_o   <= cur_io_r ? (cur_we_r ? abt_pkg::CMD_IO_WR : abt_pkg::CMD_IO_RD)
                           : (cur_we_r ? abt_pkg::CMD_MEM_WR : abt_pkg::CMD_MEM_RD);
              lcnt_r    <= 8'h00;
              gcnt_r    <= 2'h0;
            end
          end
        end
        ST_ADDR: begin
          if (pe) begin
            req_n     <= 1'b1;
            irdy_n_o  <= 1'b0;
            frame_n_o <= final_ph;
            ad_oe     <= cur_we_r;
            ad_o      <= out_d;
            cbe_n_o   <= abt_pkg::BE_ALL;
            lcnt_r    <= lcnt_r + 8'h01;
            st_r      <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (pe) begin
            lcnt_r <= (lcnt_r == 8'hFF) ? lcnt_r : lcnt_r + 8'h01;
            if (!trdy_s[1]) begin
              cur_a_r <= cur_a_r + 32'h0000_0004;
              if (!cur_we_r) begin
                lrsp_valid <= 1'b1;
                lrsp_data  <= (INCLUDE_FIFO && cur_bo_r) ? ad_s2 : abt_pkg::swap32(ad_s2);
              end
              if (frame_n_o || !take) begin
                // With no word ready the frame closes at once, so stale data is never resent.
                irdy_n_o  <= 1'b1;
                frame_n_o <= 1'b1;
                ad_oe     <= 1'b0;
                st_r      <= ST_TURN;
              end else begin
                cur_d_r    <= lreq.data;
                cur_last_r <= lreq.last;
                ad_o       <= (INCLUDE_FIFO && cur_bo_r) ? lreq.data
                              : abt_pkg::swap32(lreq.data);
                frame_n_o  <= lreq.last || expired;
              end
            end else if (expired && !frame_n_o) begin
              frame_n_o <= 1'b1;
            end
          end
        end
        ST_TURN: begin
          if (pe) begin
            ctl_oe <= 1'b0;
            // Words left after a cut burst are taken afresh in idle and request again.
            st_r   <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// *** abt_pkg_win.sv ***
package abt_pkg;
  localparam int WIN_L = 6;
  localparam int WIN_R = 3;
  typedef logic [31:0] abt_word_t;
  // Register byte offsets on the Wishbone slave.
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_LAT   = 8'h04;
  localparam logic [7:0] REG_STAT  = 8'h08;
  localparam logic [7:0] REG_RATTR = 8'h0C;
  localparam logic [7:0] REG_LOFS0 = 8'h10;
  localparam logic [7:0] REG_RBAS0 = 8'h30;
  // Field positions and reset values.
  localparam int CTRL_EN_BIT  = 0;
  localparam int ATTR_IO_BIT  = 0;
  localparam int ATTR_PF_BIT  = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0]  LAT_RST  = 8'h40;
  localparam logic [31:0] LOFS_RST = 32'h0000_0000;
  localparam logic [31:0] RBAS_RST = 32'h0000_0000;
  // Bus commands, byte enables and grant hold count.
  localparam logic [3:0] CMD_IO_RD  = 4'h2;
  localparam logic [3:0] CMD_IO_WR  = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] BE_ALL     = 4'h0;
  localparam logic [1:0] GNT_HOLD   = 2'h2;
  // Default window set.
  localparam logic [WIN_L-1:0][31:0] L_BASE_DEF  = {WIN_L{32'hFFFF_FFFF}};
  localparam logic [WIN_L-1:0][31:0] L_HIGH_DEF  = {WIN_L{32'h0000_0000}};
  localparam logic [WIN_L-1:0][31:0] L_XLATE_DEF = {WIN_L{32'hFFFF_FFFF}};
  localparam logic [WIN_L-1:0]       L_BO_DEF    = '0;
  localparam logic [WIN_L-1:0]       L_PF_DEF    = '1;
  localparam logic [WIN_L-1:0]       L_MEM_DEF   = '1;
  localparam logic [WIN_R-1:0][4:0]  R_LOG2_DEF  = {WIN_R{5'h14}};
  localparam logic [WIN_R-1:0][31:0] R_XLATE_DEF = {WIN_R{32'h0000_0000}};
  localparam logic [WIN_R-1:0]       R_BO_DEF    = '0;
  localparam logic [WIN_R-1:0]       R_PF_DEF    = '1;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic        we;
    logic        last;
  } abt_lreq_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic        we;
  } abt_treq_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic        we;
    logic [1:0]  win;
  } abt_tfwd_s;

  function automatic logic [31:0] common_mask(input logic [31:0] b, input logic [31:0] h);
    logic [31:0] m;
    logic        same;
    m = '0;
    same = 1'b1;
    for (int i = 31; i >= 0; i--) begin
      same = same & (b[i] == h[i]);
      m[i] = same;
    end
    return m;
  endfunction

  function automatic logic [31:0] size_mask(input logic [4:0] lg);
    return 32'hFFFF_FFFF << lg;
  endfunction

  function automatic logic [31:0] swap32(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
endpackage

`timescale 1ns/1ps
module abt_win (
  input  wire logic        en,
  input  wire logic        xl,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] base,
  input  wire logic [31:0] high,
  input  wire logic [31:0] mask,
  input  wire logic [31:0] repl,
  output logic             hit,
  output logic [31:0]      xaddr
);
  assign hit   = en && (addr >= base) && (addr <= high);
  assign xaddr = xl ? ((repl & mask) | (addr & ~mask)) : addr;
endmodule

// *** abt_bridge_sva.sv ***
`timescale 1ns/1ps
module abt_bridge_sva (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_ack_o,
  input wire logic               lreq_valid,
  input wire logic               lreq_ready,
  input wire logic               lrsp_valid,
  input wire logic               treq_valid,
  input wire abt_pkg::abt_tfwd_s tfwd,
  input wire logic               tfwd_valid,
  input wire logic               link_clk,
  input wire logic               req_n,
  input wire logic               frame_n_o,
  input wire logic               ctl_oe
);
  logic       lk_q;
  logic [3:0] since_r;
  // Counting from the raw link edge bounds the synchroniser delay without knowing its depth.
  always_ff @(posedge clk) begin
    lk_q <= link_clk;
    if (!rst_n || (link_clk && !lk_q))
      since_r <= 4'h0;
    else if (since_r != 4'hF)
      since_r <= since_r + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack missing");
  wb_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus ack too long");
  req_first_a: assert property ($fell(frame_n_o) |-> !$past(req_n))
    else $error("frame without request");
  req_hold_a: assert property ($fell(req_n) |=> !req_n [*8])
    else $error("request dropped early");
  link_edge_a: assert property ($changed(req_n) || $changed(frame_n_o) |-> since_r <= 4'h8)
    else $error("link output off edge");
  frame_drive_a: assert property (!frame_n_o |-> ctl_oe)
    else $error("frame low undriven");
  tfwd_cause_a: assert property (tfwd_valid |-> $past(treq_valid))
    else $error("forward without access");
  tfwd_win_a: assert property (tfwd_valid |-> tfwd.win < 2'h3)
    else $error("forward window out of range");
  ready_cause_a: assert property (lreq_ready |-> lreq_valid)
    else $error("ready without valid");
  rsp_pulse_a: assert property (lrsp_valid |=> !lrsp_valid)
    else $error("response too long");
endmodule

bind abt_bridge abt_bridge_sva abt_bridge_sva_i (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .lreq_valid, .lreq_ready, .lrsp_valid, .treq_valid, .tfwd, .tfwd_valid, .link_clk, .req_n,
  .frame_n_o, .ctl_oe);

// *** abt_link_model.sv ***
`timescale 1ns/1ps
module abt_link_model (
  input  wire logic        link_clk,
  input  wire logic        req_n,
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic [31:0] ad_o,
  input  wire logic        ad_oe,
  input  wire logic [3:0]  cbe_n,
  input  wire logic [31:0] rdata,
  output logic             gnt_n,
  output logic             trdy_n,
  output logic [31:0]      ad_i,
  output logic [31:0]      addr_seen,
  output logic [3:0]       cmd_seen,
  output logic [31:0]      wdata_seen,
  output int               words,
  output int               frames
);
  logic        fr_q    = 1'b1;
  logic        in_tx   = 1'b0;
  logic [31:0] last_ad = 32'h0000_0000;
  logic        gnt_q   = 1'b1;
  logic        trdy_q  = 1'b1;
  initial begin
    gnt_n = 1'b1;
    trdy_n = 1'b1;
    words = 0;
    frames = 0;
  end
  // An undriven bus shows a changing pattern so a stale value can never look right.
  assign ad_i = ad_oe ? ad_o : ((in_tx && !trdy_n) ? rdata : ~last_ad);
  always @(posedge link_clk) begin
    last_ad <= ad_i;
    fr_q <= frame_n;
    gnt_q <= req_n;
    if (!frame_n && fr_q) begin
      addr_seen <= ad_o;
      cmd_seen <= cbe_n;
      frames <= frames + 1;
      in_tx <= 1'b1;
    end else if (in_tx && frame_n && irdy_n) begin
      in_tx <= 1'b0;
      trdy_q <= 1'b1;
    end else if (in_tx) begin
      trdy_q <= 1'b0;
    end
    if (!irdy_n && !trdy_n) begin
      words <= words + 1;
      wdata_seen <= ad_o;
    end
  end
  // Replies leave on the falling edge, so the bridge sees each one only at the next rise.
  always @(negedge link_clk) begin
    gnt_n <= gnt_q;
    trdy_n <= trdy_q;
  end
endmodule

// *** abt_bridge_tb_top.sv ***
`timescale 1ns/1ps
module abt_bridge_tb_top;
  logic               clk = 1'b0, rst_n = 1'b0, link_clk = 1'b0;
  logic [7:0]         wb_adr_i = 8'h00;
  logic [31:0]        wb_dat_i = 32'h0, rdata = 32'h0, rd, ad_i, ad_o, lrsp_data;
  logic [31:0]        addr_seen, wdata_seen, wb_dat_o;
  logic               wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, lreq_valid = 1'b0;
  logic               treq_valid = 1'b0, wb_ack_o, lreq_ready, lrsp_valid, tfwd_valid, seen;
  logic               gnt_n, trdy_n, ad_oe, frame_n_o, irdy_n_o, ctl_oe, req_n;
  logic [3:0]         cbe_n_o, cmd_seen;
  abt_pkg::abt_lreq_s lreq = '0;
  abt_pkg::abt_treq_s treq = '0;
  abt_pkg::abt_tfwd_s tfwd;
  int                 fails = 0, tests_run = 0, words, frames, f0, w0;
  logic [31:0]        la[4] = '{32'h1234_0ABC, 32'hABCD_F123, 32'hFFFE_DCBA, 32'h0000_0071};
  logic [31:0]        ea[4] = '{32'h5671_0ABC, 32'hFEDC_1123, 32'h41FE_DCBA, 32'h8765_43F1};
  logic [31:0]        dt[4] = '{32'h1122_3344, 32'hA1B2_C3D4, 32'h5566_7788, 32'h0F1E_2D3C};
  logic [3:0]         ec[4] = '{abt_pkg::CMD_MEM_WR, abt_pkg::CMD_IO_RD, abt_pkg::CMD_MEM_WR,
                                abt_pkg::CMD_MEM_RD};
  logic [3:0]         we = 4'b0101, pass = 4'b0100;
  wire                frame_w = ctl_oe ? frame_n_o : 1'b1;
  wire                irdy_w  = ctl_oe ? irdy_n_o : 1'b1;
  always #2.5 clk = ~clk;
  always #80 link_clk = ~link_clk;
  abt_bridge #(
    .local_window_base({32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0, 32'hFE00_0000, 32'hABCD_E000,
      32'h1234_0000}),
    .local_window_high({32'h0, 32'h0, 32'h0000_007F, 32'hFFFF_FFFF, 32'hABCD_FFFF,
      32'h1234_FFFF}),
    .local_to_remote_high_bits({32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h8765_4380, 32'h4000_0000,
      32'hFEDC_0000, 32'h5671_0000}),
    .local_window_byte_order_select(6'b000100),
    .local_window_space_type(6'b111101),
    .remote_window_size_log2({5'h14, 5'h19, 5'h0B}),
    .remote_to_local_high_bits({32'h0, 32'hFE00_0000, 32'h1234_5000}),
    .remote_window_byte_order_select(3'b010)
  ) abt_bridge_i (.clk, .rst_n, .wb_adr_i, .wb_dat_i, .wb_sel_i(4'hF), .wb_we_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o, .lreq, .lreq_valid, .lreq_ready, .lrsp_data, .lrsp_valid,
    .treq, .treq_valid, .tfwd, .tfwd_valid, .link_clk, .gnt_n, .frame_n_i(frame_w),
    .irdy_n_i(irdy_w), .trdy_n, .ad_i, .ad_o, .ad_oe, .cbe_n_o, .frame_n_o, .irdy_n_o, .ctl_oe,
    .req_n);
  abt_link_model abt_link_model_i (.link_clk, .req_n, .frame_n(frame_w), .irdy_n(irdy_w), .ad_o,
    .ad_oe, .cbe_n(cbe_n_o), .rdata, .gnt_n, .trdy_n, .ad_i, .addr_seen, .cmd_seen, .wdata_seen,
    .words, .frames);
  //////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] bs(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= w;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(negedge clk); while (wb_ack_o !== 1'b1);
    @(posedge clk);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  // Valid stays up between burst words so the strobe is never driven twice in one step.
  task automatic lsend(input logic [31:0] a, input logic [31:0] d, input logic w, input logic l);
    lreq <= '{addr: a, data: d, we: w, last: l};
    lreq_valid <= 1'b1;
    do @(negedge clk); while (lreq_ready !== 1'b1);
    @(posedge clk);
    if (l)
      lreq_valid <= 1'b0;
  endtask
  task automatic wait_words(input int n);
    for (int k = 0; k < 4000 && words < n; k++) @(posedge clk);
    repeat (200) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, abt_pkg::REG_LAT, 32'h0);
    check("lat", {24'h0, abt_pkg::LAT_RST}, rd);
    wb(1'b0, abt_pkg::REG_CTRL, 32'h0);
    check("ctrl", abt_pkg::CTRL_RST, rd);
    wb(1'b0, abt_pkg::REG_LOFS0, 32'h0);
    check("lofs", abt_pkg::LOFS_RST, rd);
    wb(1'b0, abt_pkg::REG_RBAS0, 32'h0);
    check("rbas", abt_pkg::RBAS_RST, rd);
    wb(1'b0, 8'h80, 32'h0);
    check("unmapped", 32'h0, rd);
    wb(1'b0, abt_pkg::REG_RATTR, 32'h0);
    check("rattr", 32'h0008_0808, rd);
    lreq <= '{addr: la[0], data: dt[0], we: 1'b1, last: 1'b1};
    lreq_valid <= 1'b1;
    seen = 1'b0;
    repeat (40) @(negedge clk) seen = seen | lreq_ready;
    @(posedge clk);
    lreq_valid <= 1'b0;
    check("ready off", 32'h0, {31'h0, seen});
    wb(1'b1, abt_pkg::REG_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rdata <= dt[i];
      w0 = words;
      lsend(la[i], dt[i], we[i], 1'b1);
      wait_words(w0 + 1);
      check("addr", ea[i], addr_seen);
      check("cmd", {28'h0, ec[i]}, {28'h0, cmd_seen});
      if (we[i])
        check("wdata", pass[i] ? dt[i] : bs(dt[i]), wdata_seen);
      else
        check("rdata", bs(dt[i]), lrsp_data);
    end
    f0 = frames;
    lsend(32'h3000_0000, 32'h0, 1'b1, 1'b1);
    repeat (400) @(posedge clk);
    check("dropped", f0, frames);
    wb(1'b1, abt_pkg::REG_LAT, 32'h2);
    f0 = frames;
    w0 = words;
    for (int k = 0; k < 4; k++) lsend(32'h1234_0000 + 4 * k, dt[k], 1'b1, k == 3);
    wait_words(w0 + 4);
    check("words", w0 + 4, words);
    check("reframed", 32'h1, {31'h0, frames - f0 > 1});
    wb(1'b1, abt_pkg::REG_RBAS0, 32'hABCD_E800);
    wb(1'b1, abt_pkg::REG_RBAS0 + 8'h04, 32'h1200_0000);
    treq <= '{addr: 32'hABCD_EFF4, data: 32'h1234_5678, we: 1'b1};
    treq_valid <= 1'b1;
    @(posedge clk);
    treq <= '{addr: 32'h1235_FEDC, data: 32'h1234_5678, we: 1'b0};
    @(negedge clk);
    check("fwd0 addr", 32'h1234_57F4, tfwd.addr);
    check("fwd0 data", 32'h7856_3412, tfwd.data);
    check("fwd0 ctl", 32'hC, {28'h0, tfwd_valid, tfwd.we, tfwd.win});
    @(posedge clk);
    treq <= '{addr: 32'h5500_0000, data: 32'h0, we: 1'b0};
    @(negedge clk);
    check("fwd1 addr", 32'hFE35_FEDC, tfwd.addr);
    check("fwd1 data", 32'h1234_5678, tfwd.data);
    check("fwd1 ctl", 32'h9, {28'h0, tfwd_valid, tfwd.we, tfwd.win});
    @(posedge clk);
    treq_valid <= 1'b0;
    @(negedge clk);
    check("miss", 32'h0, {31'h0, tfwd_valid});
    @(posedge clk);
    wb(1'b0, abt_pkg::REG_STAT, 32'h0);
    check("idle", 32'h0, rd & 32'h7);
    end_of_test();
  end
endmodule
